/* File: rtl/cmbf_top.sv */
// Message buffer engine: dual-port shared RAM plus buffer fetch and store.
`timescale 1ns/1ps
`default_nettype none
module cmbf_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Software port of the shared RAM
	input wire logic i_sw_req,
	input wire logic i_sw_we,
	input wire logic [cmbf_pkg::ADDR_W-1:0] i_sw_addr,
	input wire logic [15:0] i_sw_wdata,
	output logic [15:0] o_sw_rdata,
	// Buffer region and buffer select
	input wire logic [cmbf_pkg::ADDR_W-1:0] i_region_base,
	input wire logic [4:0] i_buf_num,
	// Transmit fetch request
	input wire logic i_tx_start,
	output logic o_tx_hdr_valid,
	output logic [10:0] o_std_ident,
	output logic [17:0] o_ext_ident,
	output logic o_srr,
	output logic o_ide,
	output logic o_rtr,
	output logic [3:0] o_dlc,
	output logic o_tx_byte_valid,
	output logic [7:0] o_tx_byte,
	// Receive store request
	input wire logic i_rx_start,
	input wire logic [15:0] i_rx_word0,
	input wire logic [15:0] i_rx_word1,
	input wire logic [15:0] i_rx_word2,
	input wire logic [63:0] i_rx_data,
	input wire logic [4:0] i_rx_filter_hit,
	// Status
	output logic o_busy,
	output logic o_done
);
	// ************************************************************
	// Shared RAM, one port per party.
	// ************************************************************
	logic [15:0] ram [0:(1<<cmbf_pkg::ADDR_W)-1];
	cmbf_ram_if eng ();
	logic [2:0] sw_word;
	logic [15:0] sw_masked;
	logic [15:0] eng_masked;
	logic [15:0] sw_rdata_reg, sw_rdata_next;
	logic [15:0] eng_rdata_reg;
	assign sw_word = 3'(i_sw_addr - i_region_base);
	cmbf_wr_mask u_sw_mask (.i_word(sw_word), .i_data(i_sw_wdata),
		.o_data(sw_masked));
	// The word index is the offset from the region base, not the low
	// address bits, so a base that is not a multiple of eight still masks
	// the right word.
	cmbf_wr_mask u_eng_mask (.i_word(3'(eng.addr - i_region_base)),
		.i_data(eng.wdata), .o_data(eng_masked));
	always_comb begin
		sw_rdata_next = sw_rdata_reg;
		if (i_sw_req && !i_sw_we)
			sw_rdata_next = ram[i_sw_addr];
	end
	// Engine writes win the same address in one cycle; software must not
	// touch a buffer the engine is working on.
	always_ff @(posedge i_clk) begin
		if (i_sw_req && i_sw_we && !(eng.req && eng.we
			&& eng.addr == i_sw_addr))
			ram[i_sw_addr] <= sw_masked;
		if (eng.req && eng.we)
			ram[eng.addr] <= eng_masked;
		if (eng.req)
			eng_rdata_reg <= ram[eng.addr];
	end
	always_ff @(posedge i_clk) begin
		if (i_rst)
			sw_rdata_reg <= 16'h0000;
		else
			sw_rdata_reg <= sw_rdata_next;
	end
	assign eng.rdata = eng_rdata_reg;
	assign o_sw_rdata = sw_rdata_reg;
	// ************************************************************
	// Sequencer.
	// ************************************************************
	cmbf_pkg::cmbf_state_t st_reg, st_next;
	logic [3:0] idx_reg, idx_next;
	logic [3:0] cnt_reg, cnt_next;
	logic rd_pend_reg, rd_pend_next;
	logic [cmbf_pkg::ADDR_W-1:0] base_reg, base_next;
	logic hv_reg, hv_next, bv_reg, bv_next, done_reg, done_next;
	logic [10:0] sid_reg, sid_next;
	logic [17:0] eid_reg, eid_next;
	logic srr_reg, srr_next, ide_reg, ide_next, rtr_reg, rtr_next;
	logic [3:0] dlc_reg, dlc_next;
	logic [7:0] byte_reg, byte_next;
	logic [2:0] cur_word;
	logic [15:0] rx_w;
	always_comb begin
		cur_word = 3'(idx_reg);
		case (cur_word)
			cmbf_pkg::W_STD_ID: rx_w = i_rx_word0;
			cmbf_pkg::W_EXT_HI: rx_w = i_rx_word1;
			cmbf_pkg::W_EXT_LO_LEN: rx_w = i_rx_word2;
			cmbf_pkg::W_FILTER_HIT:
				rx_w = {3'h0, i_rx_filter_hit, 8'h00};
			default: rx_w = i_rx_data[16*(cur_word-3)+:16];
		endcase
	end
	always_comb begin
		st_next = st_reg;
		idx_next = idx_reg;
		cnt_next = cnt_reg;
		rd_pend_next = 1'b0;
		base_next = base_reg;
		hv_next = 1'b0;
		bv_next = 1'b0;
		done_next = 1'b0;
		sid_next = sid_reg;
		eid_next = eid_reg;
		srr_next = srr_reg;
		ide_next = ide_reg;
		rtr_next = rtr_reg;
		dlc_next = dlc_reg;
		byte_next = byte_reg;
		eng.req = 1'b0;
		eng.we = 1'b0;
		eng.addr = base_reg + {2'h0, idx_reg[2:0]};
		eng.wdata = rx_w;
		case (st_reg)
			cmbf_pkg::CMBF_IDLE: begin
				idx_next = 4'h0;
				base_next = i_region_base
					+ {i_buf_num, 3'h0};
				if (i_tx_start)
					st_next = cmbf_pkg::CMBF_TX_HDR;
				else if (i_rx_start)
					st_next = cmbf_pkg::CMBF_RX_WR;
			end
			cmbf_pkg::CMBF_TX_HDR: begin
				eng.req = !rd_pend_reg && idx_reg < 4'h3;
				rd_pend_next = eng.req;
				if (rd_pend_reg) begin
					case (idx_reg[1:0])
						2'h0: begin
							sid_next = eng.rdata[12:cmbf_pkg::SID_LSB];
							srr_next = eng.rdata[cmbf_pkg::SRR_BIT];
							ide_next = eng.rdata[cmbf_pkg::IDE_BIT];
						end
						2'h1: eid_next[17:6] = eng.rdata[11:0];
						default: begin
							eid_next[5:0] = eng.rdata[15:cmbf_pkg::EXTLO_LSB];
							rtr_next = eng.rdata[cmbf_pkg::RTR_BIT];
							dlc_next = eng.rdata[3:0];
						end
					endcase
					idx_next = idx_reg + 4'h1;
					if (idx_reg == 4'h2) begin
						hv_next = 1'b1;
						cnt_next = 4'h0;
						idx_next = {1'b0, cmbf_pkg::W_DATA_0_1};
						st_next = cmbf_pkg::CMBF_TX_DATA;
					end
				end
			end
			cmbf_pkg::CMBF_TX_DATA: begin
				if (cnt_reg >= dlc_reg || cnt_reg >= cmbf_pkg::MAX_BYTES) begin
					st_next = cmbf_pkg::CMBF_DONE;
				end else begin
					eng.req = !rd_pend_reg;
					rd_pend_next = eng.req;
					if (rd_pend_reg) begin
						byte_next = cnt_reg[0] ? eng.rdata[15:8]
							: eng.rdata[7:0];
						bv_next = 1'b1;
						cnt_next = cnt_reg + 4'h1;
						idx_next = 4'h3 + ((cnt_reg + 4'h1) >> 1);
					end
				end
			end
			cmbf_pkg::CMBF_RX_WR: begin
				eng.req = 1'b1;
				eng.we = 1'b1;
				idx_next = idx_reg + 4'h1;
				if (idx_reg == 4'h7)
					st_next = cmbf_pkg::CMBF_DONE;
			end
			cmbf_pkg::CMBF_DONE: begin
				done_next = 1'b1;
				st_next = cmbf_pkg::CMBF_IDLE;
			end
			default: st_next = cmbf_pkg::CMBF_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= cmbf_pkg::CMBF_IDLE;
			idx_reg <= 4'h0;
			cnt_reg <= 4'h0;
			rd_pend_reg <= 1'b0;
			base_reg <= '0;
			hv_reg <= 1'b0;
			bv_reg <= 1'b0;
			done_reg <= 1'b0;
			sid_reg <= 11'h000;
			eid_reg <= 18'h00000;
			srr_reg <= 1'b0;
			ide_reg <= 1'b0;
			rtr_reg <= 1'b0;
			dlc_reg <= 4'h0;
			byte_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
			rd_pend_reg <= rd_pend_next;
			base_reg <= base_next;
			hv_reg <= hv_next;
			bv_reg <= bv_next;
			done_reg <= done_next;
			sid_reg <= sid_next;
			eid_reg <= eid_next;
			srr_reg <= srr_next;
			ide_reg <= ide_next;
			rtr_reg <= rtr_next;
			dlc_reg <= dlc_next;
			byte_reg <= byte_next;
		end
	end
	logic busy_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst)
			busy_reg <= 1'b0;
		else
			busy_reg <= (st_next != cmbf_pkg::CMBF_IDLE);
	end
	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_tx_hdr_valid = hv_reg;
	assign o_std_ident = sid_reg;
	assign o_ext_ident = eid_reg;
	assign o_srr = srr_reg;
	assign o_ide = ide_reg;
	assign o_rtr = rtr_reg;
	assign o_dlc = dlc_reg;
	assign o_tx_byte_valid = bv_reg;
	assign o_tx_byte = byte_reg;
endmodule
`default_nettype wire

/* File: rtl/cmbf_pkg.sv */
// Package with the message buffer image layout and access constants.
//
// Behaviour
// - Buffers live in shared dual-port RAM, accessed by controller there.
// - Word 0: standard identifier bits 12..2, bits 15..13 zero.
// - Word 0 bit 1: substitute remote request flag.
// - Word 0 bit 0: one sends extended identifier, zero standard.
// - Word 1: extended identifier 17..6 in bits 11..0, rest zero.
// - Word 2: ext id 5..0 high, remote flag bit 9, length code 3..0.
// - Word 4 holds bytes 2 low and 3 high.
// - Words 3, 5, 6 hold bytes 0/1, 4/5, 6/7, lower byte low.
// - Word 7 bits 12..8 record the matching filter number.
// - Filter code written only for receive buffers, never transmit.
// - Word 7 bits 15..13 and 7..0 read as zero.
package cmbf_pkg;
	localparam int ADDR_W = 10;
	localparam int WORDS = 8;
	localparam logic [2:0] W_STD_ID = 3'h0;
	localparam logic [2:0] W_EXT_HI = 3'h1;
	localparam logic [2:0] W_EXT_LO_LEN = 3'h2;
	localparam logic [2:0] W_DATA_0_1 = 3'h3;
	localparam logic [2:0] W_FILTER_HIT = 3'h7;
	localparam logic [15:0] W0_MASK = 16'h1fff;
	localparam logic [15:0] W1_MASK = 16'h0fff;
	localparam logic [15:0] W2_MASK = 16'hff1f;
	localparam logic [15:0] W7_MASK = 16'h1f00;
	localparam int SID_LSB = 2;
	localparam int SRR_BIT = 1;
	localparam int IDE_BIT = 0;
	localparam int RTR_BIT = 9;
	localparam int EXTLO_LSB = 10;
	localparam int FHIT_LSB = 8;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	typedef enum logic [2:0] {
		CMBF_IDLE = 3'b000,
		CMBF_TX_HDR = 3'b001,
		CMBF_TX_DATA = 3'b010,
		CMBF_RX_WR = 3'b011,
		CMBF_DONE = 3'b100
	} cmbf_state_t;
endpackage

/* File: rtl/cmbf_ram_if.sv */
// Interface carrying one port of the shared message RAM.
`timescale 1ns/1ps
`default_nettype none
interface cmbf_ram_if;
	logic req;
	logic we;
	logic [cmbf_pkg::ADDR_W-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport master (output req, output we, output addr, output wdata,
		input rdata);
	modport port (input req, input we, input addr, input wdata,
		output rdata);
endinterface
`default_nettype wire

/* File: rtl/cmbf_wr_mask.sv */
// Word image masking so unimplemented bits always store and read as zero.
`timescale 1ns/1ps
`default_nettype none
module cmbf_wr_mask (
	// Word select and raw value
	input wire logic [2:0] i_word,
	input wire logic [15:0] i_data,
	// Masked value
	output logic [15:0] o_data
);
	always_comb begin
		case (i_word)
			cmbf_pkg::W_STD_ID: o_data = i_data & cmbf_pkg::W0_MASK;
			cmbf_pkg::W_EXT_HI: o_data = i_data & cmbf_pkg::W1_MASK;
			cmbf_pkg::W_EXT_LO_LEN: o_data = i_data & cmbf_pkg::W2_MASK;
			cmbf_pkg::W_FILTER_HIT: o_data = i_data & cmbf_pkg::W7_MASK;
			default: o_data = i_data;
		endcase
	end
endmodule
`default_nettype wire

/* File: dv/cmbf_props.sv */
// Port checker for the message buffer engine.
`timescale 1ns/1ps
`default_nettype none
module cmbf_props (
	// Watched ports
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sw_req,
	input wire logic i_sw_we,
	input wire logic [cmbf_pkg::ADDR_W-1:0] i_sw_addr,
	input wire logic [cmbf_pkg::ADDR_W-1:0] i_region_base,
	input wire logic [15:0] o_sw_rdata,
	input wire logic i_tx_start,
	input wire logic i_rx_start,
	input wire logic o_tx_hdr_valid,
	input wire logic o_tx_byte_valid,
	input wire logic [3:0] o_dlc,
	input wire logic o_busy,
	input wire logic o_done
);
	logic [cmbf_pkg::ADDR_W-1:0] off;
	logic rd;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	assign off = i_sw_addr - i_region_base;
	assign rd = i_sw_req && !i_sw_we;
	always_comb begin
		cnt_next = cnt_reg;
		if (o_tx_hdr_valid)
			cnt_next = 4'h0;
		else if (o_tx_byte_valid)
			cnt_next = cnt_reg + 4'h1;
	end
	always_ff @(posedge i_clk) begin
		cnt_reg <= i_rst ? 4'h0 : cnt_next;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_w0;
		rd && off[2:0] == 3'h0 |=> o_sw_rdata[15:13] == 3'h0;
	endproperty
	a_w0: assert property (p_w0)
		else $error("word 0 top bits set");
	property p_w1;
		rd && off[2:0] == 3'h1 |=> o_sw_rdata[15:12] == 4'h0;
	endproperty
	a_w1: assert property (p_w1)
		else $error("word 1 top bits set");
	property p_w2;
		rd && off[2:0] == 3'h2 |=> o_sw_rdata[7:5] == 3'h0;
	endproperty
	a_w2: assert property (p_w2)
		else $error("word 2 gap bits set");
	property p_w7;
		rd && off[2:0] == 3'h7 |=>
			o_sw_rdata[15:13] == 3'h0 && o_sw_rdata[7:0] == 8'h00;
	endproperty
	a_w7: assert property (p_w7)
		else $error("word 7 spare bits set");
	property p_rx;
		i_rx_start && !i_tx_start && !o_busy |-> ##10 o_done;
	endproperty
	a_rx: assert property (p_rx)
		else $error("store did not end on time");
	property p_hdr;
		i_tx_start && !o_busy |-> ##[5:10] o_tx_hdr_valid;
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header late");
	property p_cnt;
		o_tx_byte_valid |-> cnt_reg < 4'h8 && cnt_reg < o_dlc;
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("too many bytes");
	property p_gap;
		o_tx_byte_valid |=> !o_tx_byte_valid;
	endproperty
	a_gap: assert property (p_gap)
		else $error("bytes too close");
	property p_done;
		o_done |-> !o_busy ##1 !o_done;
	endproperty
	a_done: assert property (p_done)
		else $error("done not a pulse");
endmodule
`default_nettype wire

/* File: dv/cmbf_eng_model.sv */
// Protocol engine model: frame source for stores, byte sink for sends.
`timescale 1ns/1ps
`default_nettype none
module cmbf_eng_model (
	// Clock and send side
	input wire logic i_clk,
	input wire logic i_tx_byte_valid,
	input wire logic [7:0] i_tx_byte,
	// Store side
	output logic [15:0] o_w0,
	output logic [15:0] o_w1,
	output logic [15:0] o_w2,
	output logic [63:0] o_data
);
	logic [7:0] got[$];
	// Frame held constant, so it stays stable through the whole store.
	assign o_w0 = 16'h1555;
	assign o_w1 = 16'h0abc;
	assign o_w2 = 16'hfc05;
	assign o_data = 64'hf7e6d5c4b3a29180;
	always @(posedge i_clk)
		if (i_tx_byte_valid)
			got.push_back(i_tx_byte);
endmodule
`default_nettype wire

/* File: dv/tb_cmbf_top.sv */
// Testbench for the message buffer engine.
`timescale 1ns/1ps
`default_nettype none
module tb_cmbf_top;
	logic i_clk, i_rst, i_sw_req, i_sw_we, i_tx_start, i_rx_start;
	logic [cmbf_pkg::ADDR_W-1:0] i_sw_addr, i_region_base;
	logic [15:0] i_sw_wdata, o_sw_rdata, i_rx_word0, i_rx_word1, i_rx_word2;
	logic [63:0] i_rx_data;
	logic [4:0] i_buf_num, i_rx_filter_hit;
	logic [10:0] o_std_ident;
	logic [17:0] o_ext_ident;
	logic [3:0] o_dlc;
	logic [7:0] o_tx_byte;
	logic o_tx_hdr_valid, o_srr, o_ide, o_rtr, o_tx_byte_valid, o_busy, o_done;
	int fails, checked;
	cmbf_top i_cmbf_top (.i_clk(i_clk), .i_rst(i_rst), .i_sw_req(i_sw_req),
		.i_sw_we(i_sw_we), .i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata),
		.o_sw_rdata(o_sw_rdata), .i_region_base(i_region_base),
		.i_buf_num(i_buf_num), .i_tx_start(i_tx_start),
		.o_tx_hdr_valid(o_tx_hdr_valid), .o_std_ident(o_std_ident),
		.o_ext_ident(o_ext_ident), .o_srr(o_srr), .o_ide(o_ide),
		.o_rtr(o_rtr), .o_dlc(o_dlc), .o_tx_byte_valid(o_tx_byte_valid),
		.o_tx_byte(o_tx_byte), .i_rx_start(i_rx_start),
		.i_rx_word0(i_rx_word0), .i_rx_word1(i_rx_word1),
		.i_rx_word2(i_rx_word2), .i_rx_data(i_rx_data),
		.i_rx_filter_hit(i_rx_filter_hit), .o_busy(o_busy),
		.o_done(o_done));
	cmbf_eng_model i_cmbf_eng_model (.i_clk(i_clk),
		.i_tx_byte_valid(o_tx_byte_valid), .i_tx_byte(o_tx_byte),
		.o_w0(i_rx_word0), .o_w1(i_rx_word1), .o_w2(i_rx_word2),
		.o_data(i_rx_data));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [2:0] k,
		input logic [15:0] d);
		@(posedge i_clk);
		i_sw_req <= 1'b1;
		i_sw_we <= w;
		i_sw_addr <= i_region_base + {2'h0, i_buf_num, k};
		i_sw_wdata <= d;
		@(posedge i_clk);
		i_sw_req <= 1'b0;
		i_sw_we <= 1'b0;
		#1;
		if (!w)
			chk(o_sw_rdata, d);
	endtask
	task automatic go(input logic tx);
		@(posedge i_clk);
		i_tx_start <= tx;
		i_rx_start <= !tx;
		@(posedge i_clk);
		i_tx_start <= 1'b0;
		i_rx_start <= 1'b0;
		for (int i = 0; i < 60 && o_done !== 1'b1; i++)
			@(posedge i_clk);
		chk({15'h0, o_done}, 16'h0001);
	endtask
	task automatic t_tx;
		int n;
		i_buf_num <= 5'h01;
		acc(1'b1, 3'h0, 16'hffff);
		acc(1'b1, 3'h1, 16'hf123);
		acc(1'b1, 3'h2, 16'haaea);
		for (int k = 0; k < 4; k++)
			acc(1'b1, 3'(k + 3), {8'(k * 34 + 17), 8'(k * 34)});
		acc(1'b1, 3'h7, 16'hffff);
		n = i_cmbf_eng_model.got.size();
		go(1'b1);
		chk({5'h0, o_std_ident}, 16'h07ff);
		chk({14'h0, o_srr, o_ide}, 16'h0003);
		chk(o_ext_ident[17:2], {12'h123, 4'ha});
		chk({14'h0, o_ext_ident[1:0]}, 16'h0002);
		chk({11'h0, o_rtr, o_dlc}, 16'h001a);
		chk(16'(i_cmbf_eng_model.got.size() - n), 16'h0008);
		for (int k = 0; k < 8; k++)
			chk({8'h0, i_cmbf_eng_model.got[n + k]}, 16'(k * 17));
		acc(1'b0, 3'h0, 16'h1fff);
		acc(1'b0, 3'h1, 16'h0123);
		acc(1'b0, 3'h2, 16'haa0a);
		acc(1'b0, 3'h7, 16'h1f00);
	endtask
	task automatic t_len;
		int n;
		for (int d = 0; d < 10; d++) begin
			acc(1'b1, 3'h2, 16'(d));
			n = i_cmbf_eng_model.got.size();
			go(1'b1);
			n = i_cmbf_eng_model.got.size() - n;
			chk(16'(n), 16'(d > 8 ? 8 : d));
		end
	endtask
	task automatic t_rx;
		i_buf_num <= 5'h02;
		i_rx_filter_hit <= 5'h15;
		go(1'b0);
		acc(1'b0, 3'h0, 16'h1555);
		acc(1'b0, 3'h1, 16'h0abc);
		acc(1'b0, 3'h2, 16'hfc05);
		for (int k = 0; k < 4; k++)
			acc(1'b0, 3'(k + 3), i_rx_data[16 * k +: 16]);
		acc(1'b0, 3'h7, {3'h0, 5'h15, 8'h00});
	endtask
	task automatic end_of_test;
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		{i_rst, i_sw_req, i_sw_we, i_tx_start, i_rx_start} = 5'h10;
		{i_sw_addr, i_sw_wdata, i_buf_num, i_rx_filter_hit} = '0;
		// A base off the eight-word grid checks that masking follows the
		// word offset and not the raw address bits.
		i_region_base = 10'h043;
		fails = 0;
		checked = 0;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		t_tx;
		t_len;
		t_rx;
		end_of_test;
	end
	// Whole run is a few hundred cycles; this bound only catches a hang.
	initial begin
		#50us;
		fails++;
		end_of_test;
	end
endmodule
bind cmbf_top cmbf_props i_cmbf_props (.i_clk(i_clk), .i_rst(i_rst),
	.i_sw_req(i_sw_req), .i_sw_we(i_sw_we), .i_sw_addr(i_sw_addr),
	.i_region_base(i_region_base), .o_sw_rdata(o_sw_rdata),
	.i_tx_start(i_tx_start), .i_rx_start(i_rx_start),
	.o_tx_hdr_valid(o_tx_hdr_valid), .o_tx_byte_valid(o_tx_byte_valid),
	.o_dlc(o_dlc), .o_busy(o_busy), .o_done(o_done));
`default_nettype wire
